// File: common/dcp_pkg.sv
// shared constants, command codes and helpers for the control-pin link
package dcp_pkg;
  // ********************************
  // widths and counts
  // ********************************
  localparam int DQ_W = 72;
  localparam int DIES = 5;
  localparam int PAD_W = 80;
  localparam int BANKS = 8;
  localparam int ADDR_W = 13;
  localparam int MEM_W = 32;
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam logic [2:0] READ_LAT = 3'h3;

  // ********************************
  // command codes on {row, column, write} strobes
  // ********************************
  typedef logic [2:0] dcp_cmd_t;
  localparam dcp_cmd_t CMD_MODE = 3'h0;
  localparam dcp_cmd_t CMD_REF = 3'h1;
  localparam dcp_cmd_t CMD_PRE = 3'h2;
  localparam dcp_cmd_t CMD_ACT = 3'h3;
  localparam dcp_cmd_t CMD_WR = 3'h4;
  localparam dcp_cmd_t CMD_RD = 3'h5;
  localparam dcp_cmd_t CMD_NOP = 3'h7;

  // ********************************
  // mode register fields and reset values
  // ********************************
  localparam int EXT_MODE_SEL = 1;
  localparam int TERM_BIT_A = 2;
  localparam int TERM_BIT_B = 6;
  localparam int ALL_BANKS_BIT = 10;
  localparam logic [ADDR_W-1:0] BASE_MODE_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_MODE_RST = 13'h0004;

  typedef enum logic [1:0] {PWR_RUN, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF} dcp_pwr_e;

  // chip select high masks everything into a no-operation
  function automatic dcp_cmd_t dcp_decode(input logic csN, input logic rasN, input logic casN,
                                          input logic weN);
    dcp_decode = csN ? CMD_NOP : {rasN, casN, weN};
  endfunction

  function automatic logic dcp_term_allowed(input logic [ADDR_W-1:0] extMode);
    dcp_term_allowed = extMode[TERM_BIT_A] | extMode[TERM_BIT_B];
  endfunction
endpackage

// File: common/dcp_link_if.sv
// link between memory controller end and memory device end
`timescale 1ns/1ns
interface dcp_link_if;
  import dcp_pkg::*;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [2:0] bankSel;
  logic [ADDR_W-1:0] addr;
  logic termCtrl;
  logic [DIES-1:0] lowerByteMask;
  logic [DIES-2:0] upperByteMask;
  logic [DQ_W-1:0] hostDq;
  logic hostDqOe;
  logic hostStrobe;
  logic [DQ_W-1:0] devDq;
  logic devDqOe;
  logic devStrobe;
  logic [DQ_W-1:0] dq;
  logic strobe;

  // wire level worked out from the two enables
  assign dq = devDqOe ? devDq : (hostDqOe ? hostDq : '0);
  assign strobe = devDqOe ? devStrobe : (hostDqOe & hostStrobe);

  modport dev (
    input cke, csN, rasN, casN, weN, bankSel, addr, termCtrl,
    input lowerByteMask, upperByteMask, dq, strobe,
    output devDq, devDqOe, devStrobe
  );
  modport host (
    output cke, csN, rasN, casN, weN, bankSel, addr, termCtrl,
    output lowerByteMask, upperByteMask, hostDq, hostDqOe, hostStrobe,
    input dq, strobe, devDqOe
  );
endinterface

// File: rtl/dcp_mask_gate.sv
// per-die byte-lane write gate: a masked byte keeps its old value
`timescale 1ns/1ns
module dcp_mask_gate (
  input wire logic [15:0] oldWord,
  input wire logic [15:0] newWord,
  input wire logic lowMask,
  input wire logic highMask,
  output logic [15:0] outWord
);
  assign outWord[7:0] = lowMask ? oldWord[7:0] : newWord[7:0]; // [RQ14] [RQ16]
  assign outWord[15:8] = highMask ? oldWord[15:8] : newWord[15:8]; // [RQ14] [RQ16]
endmodule

// File: rtl/dcp_dev_end.sv
// memory device end: command sampling, power states, termination and masked writes
// Operation
// RQ1: termination control high switches termination on
// RQ2: termination only on data, masks, strobes
// RQ3: mode-disabled termination ignores the control input
// RQ4: sample inputs on rising clock crossing
// RQ5: read data timed to clock crossings
// RQ6: registered clock enable gates internal clocking
// RQ7: enable low: precharge/self refresh or active power-down
// RQ8: clock enable sampled for power transitions
// RQ9: self refresh exit on clock enable high
// RQ10: power-down keeps only enable and termination receivers
// RQ11: self refresh keeps only the enable receiver
// RQ12: chip select high masks every command
// RQ13: command coded on three strobes plus select
// RQ14: masked bytes are never stored
// RQ15: mask driven and sampled every beat
// RQ16: lower mask bits 0-7, upper 8-15
// RQ17: bank select chooses bank per command
// RQ18: bank select chooses mode register on load
// RQ19: eight independent banks per die
// RQ20: controller idles with select high or no-op
// RQ21: controller holds enable low through self refresh
`timescale 1ns/1ns
module dcp_dev_end
  import dcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  dcp_link_if.dev lk,
  output logic clkOn,
  output logic cmdBufOn,
  output logic termRxOn,
  output logic termOn,
  output dcp_pwr_e powerState,
  output logic [BANKS-1:0] bankOpen,
  output dcp_cmd_t lastCmd
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    dcp_pwr_e st;
    logic [BANKS-1:0] open;
    logic [3:0][ADDR_W-1:0] mode;
    logic [2:0] wrLeft;
    logic [2:0] wrBank;
    logic [1:0] wrBeat;
    logic [2:0] rdWait;
    logic [2:0] rdLeft;
    logic [2:0] rdBank;
    logic [1:0] rdBeat;
    logic [DQ_W-1:0] rdData;
    logic rdOe;
    logic rdStrobe;
    logic termOn;
    logic cmdBufOn;
    logic termRxOn;
    logic clkOn;
    dcp_cmd_t lastCmd;
    logic [MEM_W-1:0][DQ_W-1:0] mem;
  } dcp_dev_s;

  dcp_dev_s q;
  dcp_dev_s d;
  dcp_cmd_t cmd;
  logic allIdle;
  logic cmdOk;
  logic [4:0] wIdx;
  logic [PAD_W-1:0] oldPad;
  logic [PAD_W-1:0] newPad;
  logic [PAD_W-1:0] mergedPad;
  logic [DIES-1:0] hiMask;

  // ********************************
  // byte-lane gating per die
  // ********************************
  assign wIdx = {q.wrBank, q.wrBeat};
  assign oldPad = {8'h00, q.mem[wIdx]};
  assign newPad = {8'h00, lk.dq};
  // the last die carries only a lower byte; its upper lane is always held
  assign hiMask = {1'b1, lk.upperByteMask};

  genvar gi;
  generate
    for (gi = 0; gi < DIES; gi++) begin : g_die
      dcp_mask_gate dcp_mask_gate_inst (
        .oldWord(oldPad[gi*16 +: 16]),
        .newWord(newPad[gi*16 +: 16]),
        .lowMask(lk.lowerByteMask[gi]),
        .highMask(hiMask[gi]),
        .outWord(mergedPad[gi*16 +: 16])
      ); // [RQ16]
    end
  endgenerate

  // ********************************
  // next state
  // ********************************
  always_comb begin
    d = q;
    // inputs are read only as they stand at the rising edge
    cmd = dcp_decode(lk.csN, lk.rasN, lk.casN, lk.weN); // [RQ4] [RQ12] [RQ13]
    allIdle = (q.open == '0);
    // a command needs the enable high on this edge and the one before
    cmdOk = (q.st == PWR_RUN) && q.clkOn && lk.cke; // [RQ8]
    d.clkOn = lk.cke; // [RQ6]

    case (q.st)
      PWR_RUN: begin
        if (!lk.cke) begin
          if (allIdle && cmd == CMD_REF && q.clkOn) begin
            d.st = PWR_SELF; // [RQ7]
          end else if (allIdle) begin
            d.st = PWR_PDN_PRE; // [RQ7]
          end else begin
            d.st = PWR_PDN_ACT; // [RQ7]
          end
        end
      end
      PWR_PDN_PRE, PWR_PDN_ACT: begin
        if (lk.cke) begin
          d.st = PWR_RUN; // [RQ8]
        end
      end
      PWR_SELF: begin
        // only the enable receiver is alive; no command is needed to leave
        if (lk.cke) begin
          d.st = PWR_RUN; // [RQ9]
        end
      end
      default: begin
        d.st = PWR_RUN;
      end
    endcase

    if (cmdOk) begin
      d.lastCmd = cmd;
      case (cmd)
        CMD_ACT: begin
          d.open[lk.bankSel] = 1'b1; // [RQ17] [RQ19]
        end
        CMD_PRE: begin
          if (lk.addr[ALL_BANKS_BIT]) begin
            d.open = '0;
          end else begin
            d.open[lk.bankSel] = 1'b0; // [RQ17]
          end
        end
        CMD_WR: begin
          if (q.open[lk.bankSel]) begin
            d.wrLeft = BURST_BEATS;
            d.wrBank = lk.bankSel; // [RQ17]
            d.wrBeat = 2'h0;
          end
        end
        CMD_RD: begin
          if (q.open[lk.bankSel]) begin
            d.rdWait = READ_LAT;
            d.rdLeft = BURST_BEATS;
            d.rdBank = lk.bankSel; // [RQ17]
            d.rdBeat = 2'h0;
          end
        end
        CMD_MODE: begin
          // loading a mode register while a row is open is ignored
          if (allIdle) begin
            d.mode[lk.bankSel[1:0]] = lk.addr; // [RQ18]
          end
        end
        default: begin
        end
      endcase
    end

    // ********************************
    // write beats, one mask sample per beat
    // ********************************
    if (q.wrLeft != 3'h0) begin
      d.mem[wIdx] = mergedPad[DQ_W-1:0]; // [RQ14] [RQ15]
      d.wrBeat = q.wrBeat + 2'h1;
      d.wrLeft = q.wrLeft - 3'h1;
    end

    // ********************************
    // read beats, launched on the clock edge
    // ********************************
    d.rdOe = 1'b0;
    if (q.rdWait != 3'h0) begin
      d.rdWait = q.rdWait - 3'h1;
    end else if (q.rdLeft != 3'h0) begin
      d.rdData = q.mem[{q.rdBank, q.rdBeat}]; // [RQ5]
      d.rdOe = 1'b1; // [RQ5]
      d.rdStrobe = ~q.rdStrobe; // [RQ5]
      d.rdBeat = q.rdBeat + 2'h1;
      d.rdLeft = q.rdLeft - 3'h1;
    end
    if (!d.rdOe) begin
      d.rdStrobe = 1'b0;
    end

    // ********************************
    // receivers and termination
    // ********************************
    d.cmdBufOn = (d.st == PWR_RUN); // [RQ10] [RQ11]
    d.termRxOn = (d.st != PWR_SELF); // [RQ10] [RQ11]
    // one enable serves data, mask and strobe lanes and nothing else
    d.termOn = lk.termCtrl && dcp_term_allowed(q.mode[EXT_MODE_SEL]) && d.termRxOn; // [RQ1] [RQ2] [RQ3]
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.mode[0] <= BASE_MODE_RST;
      q.mode[EXT_MODE_SEL] <= EXT_MODE_RST;
      q.lastCmd <= CMD_NOP;
      q.cmdBufOn <= 1'b1;
      q.termRxOn <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign lk.devDq = q.rdData;
  assign lk.devDqOe = q.rdOe;
  assign lk.devStrobe = q.rdStrobe;
  assign clkOn = q.clkOn;
  assign cmdBufOn = q.cmdBufOn;
  assign termRxOn = q.termRxOn;
  assign termOn = q.termOn;
  assign powerState = q.st;
  assign bankOpen = q.open;
  assign lastCmd = q.lastCmd;
endmodule

// File: rtl/dcp_host_end.sv
// memory controller end: drives commands, enable, termination, masks and write beats
`timescale 1ns/1ns
module dcp_host_end
  import dcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  dcp_link_if.host lk,
  input wire logic cmdValid,
  input wire dcp_cmd_t cmdOp,
  input wire logic [2:0] cmdBank,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DQ_W-1:0] wrWord,
  input wire logic [DIES-1:0] wrMaskLo,
  input wire logic [DIES-2:0] wrMaskHi,
  input wire logic ckeReq,
  input wire logic termReq,
  output logic cmdReady,
  output logic [DQ_W-1:0] rdWord,
  output logic rdValid
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic cke;
    logic csN;
    dcp_cmd_t op;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
    logic term;
    logic [DIES-1:0] maskLo;
    logic [DIES-2:0] maskHi;
    logic [DQ_W-1:0] dq;
    logic dqOe;
    logic strobe;
    logic [2:0] wrLeft;
    logic [2:0] rdLeft;
    logic [DQ_W-1:0] rdWord;
    logic rdValid;
    logic ready;
  } dcp_host_s;

  dcp_host_s q;
  dcp_host_s d;
  logic take;

  always_comb begin
    d = q;
    take = cmdValid && q.ready;
    d.cke = ckeReq; // [RQ8] [RQ21]
    d.term = termReq;
    // idle cycles carry select high; the code lines keep the last command, so the device must mask it
    d.csN = 1'b1; // [RQ20]
    if (take) begin
      d.csN = 1'b0; // [RQ13]
      d.op = cmdOp; // [RQ13]
      d.bank = cmdBank; // [RQ17]
      d.addr = cmdAddr;
      if (cmdOp == CMD_WR) begin
        d.wrLeft = BURST_BEATS;
        d.dq = wrWord;
        d.maskLo = wrMaskLo;
        d.maskHi = wrMaskHi;
      end
      if (cmdOp == CMD_RD) begin
        d.rdLeft = BURST_BEATS;
      end
    end

    // ********************************
    // write beats; the mask is presented with every beat
    // ********************************
    d.dqOe = 1'b0;
    d.strobe = 1'b0;
    if (q.wrLeft != 3'h0) begin
      d.dqOe = 1'b1; // [RQ15]
      d.strobe = ~q.strobe; // [RQ15]
      d.wrLeft = q.wrLeft - 3'h1;
    end

    // ********************************
    // read capture
    // ********************************
    d.rdValid = 1'b0;
    if (lk.devDqOe && q.rdLeft != 3'h0) begin
      d.rdWord = lk.dq;
      d.rdValid = 1'b1;
      d.rdLeft = q.rdLeft - 3'h1;
    end
    // one burst in flight at a time keeps the beat bookkeeping trivial
    d.ready = (d.wrLeft == 3'h0) && (d.rdLeft == 3'h0) && !take;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.csN <= 1'b1;
      q.op <= CMD_NOP;
    end else begin
      q <= d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign lk.cke = q.cke;
  assign lk.csN = q.csN;
  assign lk.rasN = q.op[2];
  assign lk.casN = q.op[1];
  assign lk.weN = q.op[0];
  assign lk.bankSel = q.bank;
  assign lk.addr = q.addr;
  assign lk.termCtrl = q.term;
  assign lk.lowerByteMask = q.maskLo;
  assign lk.upperByteMask = q.maskHi;
  assign lk.hostDq = q.dq;
  assign lk.hostDqOe = q.dqOe;
  assign lk.hostStrobe = q.strobe;
  assign cmdReady = q.ready;
  assign rdWord = q.rdWord;
  assign rdValid = q.rdValid;
endmodule

// File: dv/dcp_link_checker.sv
// concurrent checks on the control-pin link and the device end outputs
`timescale 1ns/1ns
module dcp_link_checker
  import dcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] bankSel,
  input wire logic [DIES-1:0] lowerByteMask,
  input wire logic [DIES-2:0] upperByteMask,
  input wire logic hostDqOe,
  input wire logic hostStrobe,
  input wire logic devDqOe,
  input wire logic strobe,
  input wire logic termOn,
  input dcp_pwr_e powerState,
  input wire logic [BANKS-1:0] bankOpen,
  input wire logic clkOn,
  input wire logic cmdBufOn,
  input wire logic termRxOn
);
  dcp_pwr_e pdnNext;
  assign pdnNext = (bankOpen == '0) ? PWR_PDN_PRE : PWR_PDN_ACT;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_CS_MASK: assert property (bankOpen != $past(bankOpen) |-> !$past(csN))
    else $error("bank state changed without chip select");
  AST_CMD_ONE_CYCLE: assert property (!csN |=> csN)
    else $error("command held longer than one cycle");
  AST_RD_LAT: assert property (!csN && {rasN, casN, weN} == CMD_RD && bankOpen[bankSel] &&
    powerState == PWR_RUN && cke && $past(cke) |-> ##5 devDqOe) else $error("read data late");
  AST_RD_BURST: assert property ($rose(devDqOe) |-> devDqOe [*4] ##1 !devDqOe)
    else $error("read burst length wrong");
  AST_RD_STROBE: assert property ($rose(devDqOe) |-> strobe ##1 !strobe ##1 strobe ##1 !strobe)
    else $error("read strobe pattern wrong");
  AST_WR_STROBE: assert property ($rose(hostDqOe) |-> hostStrobe ##1 !hostStrobe ##1 hostStrobe
    ##1 !hostStrobe ##1 !hostDqOe) else $error("write strobe pattern wrong");
  AST_MASK_HOLD: assert property (hostDqOe && $past(hostDqOe) |->
    $stable(lowerByteMask) && $stable(upperByteMask)) else $error("mask changed inside burst");
  AST_PWR_ENTRY: assert property (powerState == PWR_RUN && !cke &&
    (csN || {rasN, casN, weN} != CMD_REF) |=> powerState == $past(pdnNext)) else $error("power-down entry wrong");
  AST_PWR_EXIT: assert property (powerState != PWR_RUN && cke |=> powerState == PWR_RUN && cmdBufOn)
    else $error("power exit missed");
  AST_BUF_GATE: assert property (cmdBufOn == (powerState == PWR_RUN) &&
    termRxOn == (powerState != PWR_SELF)) else $error("input buffer gating wrong");
  AST_CLK_ON: assert property (clkOn == $past(cke))
    else $error("clocking enable does not follow cke");
  AST_SELF_TERM: assert property (powerState == PWR_SELF [*2] |-> !termOn)
    else $error("termination on in self refresh");

  cover property (powerState == PWR_SELF);
  cover property (powerState == PWR_PDN_ACT);
  cover property ($rose(devDqOe));
  cover property ($rose(hostDqOe));
  cover property (csN && {rasN, casN, weN} == CMD_WR);
endmodule

// File: dv/tb_ddr2_control_pin_logic.sv
// self-checking bench: controller end and device end joined by the link
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module tb_ddr2_control_pin_logic
  import dcp_pkg::*;
;
  logic clk_sys = 0, rst_b = 0, cmdValid = 0, ckeReq = 0, termReq = 0;
  dcp_cmd_t cmdOp = CMD_NOP;
  logic [2:0] cmdBank = '0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [DQ_W-1:0] wrWord = '0, wA, wB, rdWord;
  logic [DIES-1:0] wrMaskLo = '0;
  logic [DIES-2:0] wrMaskHi = '0;
  logic cmdReady, rdValid, clkOn, cmdBufOn, termRxOn, termOn;
  dcp_pwr_e powerState;
  logic [BANKS-1:0] bankOpen;
  dcp_cmd_t lastCmd;
  int n_mismatch = 0, compares = 0, beats, r;
  integer seed = 32'hd8f8;
  logic [2:0] b;

  dcp_link_if lk();
  dcp_host_end dcp_host_end_inst (.clk_sys(clk_sys), .rst_b(rst_b), .lk(lk), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .wrWord(wrWord), .wrMaskLo(wrMaskLo),
    .wrMaskHi(wrMaskHi), .ckeReq(ckeReq), .termReq(termReq), .cmdReady(cmdReady), .rdWord(rdWord),
    .rdValid(rdValid));
  dcp_dev_end dcp_dev_end_inst (.clk_sys(clk_sys), .rst_b(rst_b), .lk(lk), .clkOn(clkOn),
    .cmdBufOn(cmdBufOn), .termRxOn(termRxOn), .termOn(termOn), .powerState(powerState),
    .bankOpen(bankOpen), .lastCmd(lastCmd));
  dcp_link_checker dcp_link_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cke(lk.cke), .csN(lk.csN),
    .rasN(lk.rasN), .casN(lk.casN), .weN(lk.weN), .bankSel(lk.bankSel), .lowerByteMask(lk.lowerByteMask),
    .upperByteMask(lk.upperByteMask), .hostDqOe(lk.hostDqOe), .hostStrobe(lk.hostStrobe),
    .devDqOe(lk.devDqOe), .strobe(lk.strobe), .termOn(termOn), .powerState(powerState), .bankOpen(bankOpen),
    .clkOn(clkOn), .cmdBufOn(cmdBufOn), .termRxOn(termRxOn));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ********************************
  // helpers
  // ********************************
  // a masked lane keeps the old byte; die 4 has no upper lane
  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] old, input logic [DQ_W-1:0] nw,
                                            input logic [DIES-1:0] lo, input logic [DIES-2:0] hi);
    merge = nw;
    for (int d = 0; d < DIES; d++) begin
      if (lo[d]) merge[16*d+:8] = old[16*d+:8];
      if (d < DIES - 1 && hi[d]) merge[16*d+8+:8] = old[16*d+8+:8];
    end
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // ready is settled at the falling edge, so the next rising edge is the take
  task automatic issue(input dcp_cmd_t op, input logic [2:0] bk, input logic [ADDR_W-1:0] ad, input logic ck);
    int t;
    t = 0;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1 && t < 40) begin
      @(negedge clk_sys);
      t++;
    end
    `CHK(cmdReady, 1'b1, "controller never ready")
    cmdValid = 1;
    cmdOp = op;
    cmdBank = bk;
    cmdAddr = ad;
    ckeReq = ck;
    @(negedge clk_sys);
    cmdValid = 0;
  endtask

  task automatic read_check(input logic [2:0] bk, input logic [DQ_W-1:0] exp);
    issue(CMD_RD, bk, '0, 1);
    beats = 0;
    for (int t = 0; t < 20 && beats < BURST_BEATS; t++) begin
      if (rdValid === 1'b1) begin
        `CHK(rdWord, exp, "read word")
        beats++;
      end
      @(negedge clk_sys);
    end
    `CHK(beats, BURST_BEATS, "read beat count")
  endtask

  task automatic stop_test;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(50 * 6000);
    n_mismatch++;
    stop_test;
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    idle(12);
    `CHK({cmdBufOn, termRxOn, lastCmd, powerState, bankOpen}, {2'h3, CMD_NOP, PWR_RUN, 8'h00}, "reset")
    rst_b = 1;
    ckeReq = 1;
    termReq = 1;
    idle(5);
    `CHK(termOn, 1'b1, "termination on")
    for (r = 0; r < 3; r++) begin
      b = 3'($random(seed));
      wA = 72'({$random(seed), $random(seed), $random(seed)});
      wB = 72'({$random(seed), $random(seed), $random(seed)});
      issue(CMD_ACT, b, '0, 1);
      idle(1);
      `CHK({bankOpen[b], lastCmd}, {1'b1, CMD_ACT}, "activate")
      wrWord = wA;
      {wrMaskLo, wrMaskHi} = '0;
      issue(CMD_WR, b, '0, 1);
      wrWord = wB;
      wrMaskLo = (r == 0) ? 5'h15 : 5'($random(seed));
      wrMaskHi = (r == 0) ? 4'ha : 4'($random(seed));
      issue(CMD_WR, b, '0, 1);
      read_check(b, merge(wA, wB, wrMaskLo, wrMaskHi));
      issue(CMD_PRE, b, 13'h0400, 1);
      idle(1);
      `CHK(bankOpen, 8'h00, "precharge all")
    end
    issue(CMD_MODE, 3'h1, 13'h0000, 1);
    idle(3);
    `CHK(termOn, 1'b0, "termination disabled by mode")
    issue(CMD_MODE, 3'h0, 13'h0040, 1);
    idle(3);
    `CHK(termOn, 1'b0, "base register load")
    issue(CMD_MODE, 3'h1, 13'h0040, 1);
    idle(3);
    `CHK(termOn, 1'b1, "extended register load")
    issue(CMD_ACT, 3'h7, '0, 1);
    issue(CMD_NOP, 3'h0, '0, 0);
    idle(3);
    `CHK({powerState, cmdBufOn, termRxOn}, {PWR_PDN_ACT, 2'h1}, "active power-down")
    issue(CMD_PRE, 3'h7, 13'h0400, 0);
    idle(2);
    `CHK(bankOpen[7], 1'b1, "command ignored in power-down")
    ckeReq = 1;
    idle(4);
    `CHK(powerState, PWR_RUN, "power-down exit")
    issue(CMD_PRE, 3'h7, 13'h0400, 1);
    issue(CMD_NOP, 3'h0, '0, 0);
    idle(3);
    `CHK(powerState, PWR_PDN_PRE, "precharge power-down")
    ckeReq = 1;
    idle(4);
    issue(CMD_REF, 3'h0, '0, 0);
    idle(3);
    `CHK({powerState, termRxOn, termOn}, {PWR_SELF, 2'h0}, "self refresh")
    ckeReq = 1;
    idle(2);
    `CHK({powerState, cmdBufOn}, {PWR_RUN, 1'b1}, "self refresh exit")
    stop_test;
  end
endmodule
